// *** rtl/puwcm_defines.svh ***
`ifndef PUWCM_DEFINES_SVH
`define PUWCM_DEFINES_SVH
// Notes on behaviour
// - Strap low selects 100 MHz differential reference, high selects 125 MHz.
// - Beacon is produced only if the beacon enable bit 10 is set when the wake request starts.
// - In L2 with beacon enabled, a secondary PME request starts beacon.
// - Beacon toggles near 500 kHz, within 50 percent, without de-emphasis.
// - Beacon continues until fundamental reset goes inactive, then stops.
// - In L2, a secondary PME event drives the WAKE output low.
// - WAKE stays low until fundamental reset goes inactive, then releases.
// - WAKE is only pulled low or left undriven, never driven high.
// - Advertise 8 posted header and 128 posted data credits.
// - Advertise 4 non-posted header and 4 non-posted data credits.
// - Advertise 0, meaning unlimited, for completion header and data.
// - Initial credits are identical with or without the second channel.
// - Interrupt, PME, turn-off ack and error messages are sent upstream.
// - ASPM Nak, turn-off and slot power limit messages are processed.
// - Unlock, hot-plug, switching and vendor type 1 are silently dropped.
// - Vendor-defined type 0 messages are answered as unsupported request.

// Reference clock figures in MHz.
`define PUWCM_REF_DIFF_MHZ 100
`define PUWCM_REF_SE_MHZ 125
`define PUWCM_BEACON_EN_BIT 10
// Beacon frequency in kHz; link clock in kHz.
`define PUWCM_BEACON_KHZ 500
`define PUWCM_LINK_KHZ 31250
// Half period of beacon in link cycles: 31250 / (2 * 500) = 31.
`define PUWCM_BEACON_HALF (`PUWCM_LINK_KHZ / (2 * `PUWCM_BEACON_KHZ))
`define PUWCM_CR_PH 8'h08
`define PUWCM_CR_PD 12'h080
`define PUWCM_CR_NPH 8'h04
`define PUWCM_CR_NPD 12'h004
`define PUWCM_CR_CPLH 8'h00
`define PUWCM_CR_CPLD 12'h000
`endif

// *** rtl/puwcm_pkg.sv ***
package puwcm_pkg;
    // Received message classes presented by the link logic.
    typedef enum logic [3:0] {
        PUWCM_RX_ASPM_NAK = 4'h0,
        PUWCM_RX_TURN_OFF = 4'h1,
        PUWCM_RX_SLOT_PWR = 4'h2,
        PUWCM_RX_UNLOCK = 4'h3,
        PUWCM_RX_HOTPLUG = 4'h4,
        PUWCM_RX_ADV_SW = 4'h5,
        PUWCM_RX_VDM0 = 4'h6,
        PUWCM_RX_VDM1 = 4'h7
    } puwcm_rx_msg_e;
    // Messages originated by the bridge.
    typedef enum logic [2:0] {
        PUWCM_TX_ASSERT_INTX = 3'h0,
        PUWCM_TX_DEASSERT_INTX = 3'h1,
        PUWCM_TX_PM_PME = 3'h2,
        PUWCM_TX_PME_TO_ACK = 3'h3,
        PUWCM_TX_ERR_COR = 3'h4,
        PUWCM_TX_ERR_NONFATAL = 3'h5,
        PUWCM_TX_ERR_FATAL = 3'h6
    } puwcm_tx_msg_e;
    typedef enum logic [2:0] {
        PUWCM_W_IDLE = 3'b001,
        PUWCM_W_WAKE = 3'b010,
        PUWCM_W_HOLD = 3'b100
    } puwcm_wake_e;
endpackage : puwcm_pkg

// *** rtl/puwcm_top.sv ***
`timescale 1ns/10ps
`include "puwcm_defines.svh"
module puwcm_top
    import puwcm_pkg::*;
#(
    parameter int BEACON_HALF = `PUWCM_BEACON_HALF
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_link_clk,
    input wire logic i_ref_clock_type_strap,
    input wire logic i_perst_n,
    input wire logic [31:0] i_gen_ctrl,
    input wire logic i_link_in_l2,
    input wire logic i_sec_pme_n,
    input wire logic i_vc1_enable,
    input wire logic i_tx_req,
    input wire logic [2:0] i_tx_msg,
    input wire logic i_rx_valid,
    input wire logic [3:0] i_rx_msg,
    output logic o_ref_sel_125,
    output logic o_beacon,
    output logic o_beacon_active,
    output logic o_beacon_deemph,
    output logic o_wake_n_o,
    output logic o_wake_n_oe,
    output logic [7:0] o_cr_ph,
    output logic [11:0] o_cr_pd,
    output logic [7:0] o_cr_nph,
    output logic [11:0] o_cr_npd,
    output logic [7:0] o_cr_cplh,
    output logic [11:0] o_cr_cpld,
    output logic o_tx_valid,
    output logic [2:0] o_tx_msg,
    output logic o_rx_aspm_nak,
    output logic o_rx_turn_off,
    output logic o_rx_slot_pwr,
    output logic o_rx_drop,
    output logic o_rx_ur
);

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    // Every pin below is asynchronous to the core clock. Three
    // stages are kept, and a level is only taken once the second
    // and third agree, so a glitch shorter than a cycle is ignored.
    logic [2:0] pme_sync_r;
    logic [2:0] perst_sync_r;
    logic [2:0] strap_sync_r;
    logic pme_r;
    logic perst_r;
    logic strap_r;
    logic perst_prev_r;

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            pme_sync_r <= 3'h7;
            pme_r <= 1'b1;
        end else if (i_ce) begin
            pme_sync_r <= {pme_sync_r[1:0], i_sec_pme_n};
            if (pme_sync_r[1] == pme_sync_r[2]) begin
                pme_r <= pme_sync_r[2];
            end
        end
    end

    // PERST resets to its asserted level, so the first release
    // after reset is seen as a rising edge and latches the strap.
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            perst_sync_r <= 3'h0;
            perst_r <= 1'b0;
            perst_prev_r <= 1'b0;
        end else if (i_ce) begin
            perst_sync_r <= {perst_sync_r[1:0], i_perst_n};
            if (perst_sync_r[1] == perst_sync_r[2]) begin
                perst_r <= perst_sync_r[2];
            end
            perst_prev_r <= perst_r;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            strap_sync_r <= 3'h0;
            strap_r <= 1'b0;
        end else if (i_ce) begin
            strap_sync_r <= {strap_sync_r[1:0], i_ref_clock_type_strap};
            if (strap_sync_r[1] == strap_sync_r[2]) begin
                strap_r <= strap_sync_r[2];
            end
        end
    end

    wire perst_rise = perst_r && !perst_prev_r;

    // ==========================================================
    // Reference clock strap
    // ==========================================================
    // The strap follows the pin while PERST is held and is frozen at
    // the PERST release, so a strap moved during normal operation
    // cannot swap the reference under a running link.
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_ref_sel_125 <= 1'b0;
        end else if (i_ce) begin
            if (perst_rise || !perst_r) begin
                o_ref_sel_125 <= strap_r;
            end
        end
    end

    // ==========================================================
    // Wake and beacon request
    // ==========================================================
    puwcm_wake_e wstate_r;
    logic beacon_req_r;

    wire beacon_en = i_gen_ctrl[`PUWCM_BEACON_EN_BIT];
    wire pme_evt = i_link_in_l2 && !pme_r;

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            wstate_r <= PUWCM_W_IDLE;
            beacon_req_r <= 1'b0;
        end else if (i_ce) begin
            case (wstate_r)
                PUWCM_W_IDLE: begin
                    if (pme_evt) begin
                        wstate_r <= PUWCM_W_WAKE;
                        beacon_req_r <= beacon_en;
                    end
                end
                PUWCM_W_WAKE: begin
                    // Only the PERST release ends a wake request.
                    if (perst_rise) begin
                        wstate_r <= PUWCM_W_HOLD;
                        beacon_req_r <= 1'b0;
                    end
                end
                PUWCM_W_HOLD: begin
                    wstate_r <= PUWCM_W_IDLE;
                end
                default: begin
                    wstate_r <= PUWCM_W_IDLE;
                    beacon_req_r <= 1'b0;
                end
            endcase
        end
    end

    // Open drain: the data bit is tied low and only the enable
    // moves, so the pin is never driven high against the system
    // pull-up, which alone sets the inactive level.
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_wake_n_o <= 1'b0;
        end else if (i_ce) begin
            o_wake_n_o <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_wake_n_oe <= 1'b0;
        end else if (i_ce) begin
            o_wake_n_oe <= (wstate_r == PUWCM_W_WAKE);
        end
    end

    // ==========================================================
    // Beacon generator on the link clock
    // ==========================================================
    // The link clock may stop; the request crosses as a level.
    // Reset and the clock enable cross the same way, so the tone
    // generator starts from a known state and freezes with the core.
    logic [2:0] lk_req_sync_r;
    logic [2:0] lk_ce_sync_r;
    logic [2:0] lk_rst_sync_r;
    logic lk_req_r;
    logic lk_ce_r;
    logic lk_rstn_r;
    logic [7:0] lk_cnt_r;
    logic lk_beacon_r;

    localparam logic [7:0] HALF_M1 = 8'(BEACON_HALF - 1);

    // The tone counter must be able to hold one half period.
    if (BEACON_HALF < 1 || BEACON_HALF > 2 ** $bits(lk_cnt_r)) begin : g_chk
        $error("BEACON_HALF is outside the range of the tone counter.");
    end

    // This synchroniser has no reset of its own: it settles once
    // the core reset has been low for a few link clocks.
    always_ff @(posedge i_link_clk) begin
        lk_rst_sync_r <= {lk_rst_sync_r[1:0], i_rstn};
        if (lk_rst_sync_r[1] == lk_rst_sync_r[2]) begin
            lk_rstn_r <= lk_rst_sync_r[2];
        end
    end

    always_ff @(posedge i_link_clk) begin
        lk_req_sync_r <= {lk_req_sync_r[1:0], beacon_req_r};
        lk_ce_sync_r <= {lk_ce_sync_r[1:0], i_ce};
        if (!lk_rstn_r) begin
            lk_req_r <= 1'b0;
            lk_ce_r <= 1'b1;
        end else begin
            if (lk_req_sync_r[1] == lk_req_sync_r[2]) begin
                lk_req_r <= lk_req_sync_r[2];
            end
            if (lk_ce_sync_r[1] == lk_ce_sync_r[2]) begin
                lk_ce_r <= lk_ce_sync_r[2];
            end
        end
    end

    // The half period counts link clocks; BEACON_HALF must match
    // the link clock in use for the tone to stay inside its band.
    always_ff @(posedge i_link_clk) begin
        if (!lk_rstn_r) begin
            lk_cnt_r <= 8'h00;
            lk_beacon_r <= 1'b0;
        end else if (lk_ce_r) begin
            if (!lk_req_r) begin
                lk_cnt_r <= 8'h00;
                lk_beacon_r <= 1'b0;
            end else if (lk_cnt_r == HALF_M1) begin
                lk_cnt_r <= 8'h00;
                lk_beacon_r <= !lk_beacon_r;
            end else begin
                lk_cnt_r <= lk_cnt_r + 8'h01;
            end
        end
    end

    assign o_beacon = lk_beacon_r;

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_beacon_active <= 1'b0;
        end else if (i_ce) begin
            o_beacon_active <= beacon_req_r;
        end
    end

    // The transmitter never applies de-emphasis to the beacon tone.
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_beacon_deemph <= 1'b0;
        end else if (i_ce) begin
            o_beacon_deemph <= 1'b0;
        end
    end

    // ==========================================================
    // Initial flow-control credits
    // ==========================================================
    // The values are constants held in flops so that every output
    // leaves a register. The VC1 enable is deliberately not read:
    // the advertisement is the same with one channel or two.
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_cr_ph <= `PUWCM_CR_PH;
            o_cr_pd <= `PUWCM_CR_PD;
        end else if (i_ce) begin
            o_cr_ph <= `PUWCM_CR_PH;
            o_cr_pd <= `PUWCM_CR_PD;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_cr_nph <= `PUWCM_CR_NPH;
            o_cr_npd <= `PUWCM_CR_NPD;
        end else if (i_ce) begin
            o_cr_nph <= `PUWCM_CR_NPH;
            o_cr_npd <= `PUWCM_CR_NPD;
        end
    end

    // A zero completion advertisement means unlimited credit.
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_cr_cplh <= `PUWCM_CR_CPLH;
            o_cr_cpld <= `PUWCM_CR_CPLD;
        end else if (i_ce) begin
            o_cr_cplh <= `PUWCM_CR_CPLH;
            o_cr_cpld <= `PUWCM_CR_CPLD;
        end
    end

    // ==========================================================
    // Message routing
    // ==========================================================
    function automatic logic tx_ok(input logic [2:0] m);
        tx_ok = (m <= PUWCM_TX_ERR_FATAL);
    endfunction : tx_ok

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_tx_valid <= 1'b0;
            o_tx_msg <= 3'h0;
        end else if (i_ce) begin
            o_tx_valid <= i_tx_req && tx_ok(i_tx_msg);
            if (i_tx_req) begin
                o_tx_msg <= i_tx_msg;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_rx_aspm_nak <= 1'b0;
            o_rx_turn_off <= 1'b0;
            o_rx_slot_pwr <= 1'b0;
            o_rx_drop <= 1'b0;
            o_rx_ur <= 1'b0;
        end else if (i_ce) begin
            o_rx_aspm_nak <= 1'b0;
            o_rx_turn_off <= 1'b0;
            o_rx_slot_pwr <= 1'b0;
            o_rx_drop <= 1'b0;
            o_rx_ur <= 1'b0;
            if (i_rx_valid) begin
                case (i_rx_msg)
                    PUWCM_RX_ASPM_NAK: o_rx_aspm_nak <= 1'b1;
                    PUWCM_RX_TURN_OFF: o_rx_turn_off <= 1'b1;
                    PUWCM_RX_SLOT_PWR: o_rx_slot_pwr <= 1'b1;
                    PUWCM_RX_UNLOCK,
                    PUWCM_RX_HOTPLUG,
                    PUWCM_RX_ADV_SW,
                    PUWCM_RX_VDM1: o_rx_drop <= 1'b1;
                    PUWCM_RX_VDM0: o_rx_ur <= 1'b1;
                    default: o_rx_ur <= 1'b1;
                endcase
            end
        end
    end

endmodule : puwcm_top

// *** bench/puwcm_checker.sv ***
`timescale 1ns/10ps
// ==========================================================
// Port checker for the upstream housekeeping block.
module puwcm_checker (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_tx_req,
    input wire logic [2:0] i_tx_msg,
    input wire logic i_rx_valid,
    input wire logic [3:0] i_rx_msg,
    input wire logic o_beacon_deemph,
    input wire logic o_wake_n_o,
    input wire logic [7:0] o_cr_ph,
    input wire logic [11:0] o_cr_pd,
    input wire logic [7:0] o_cr_nph,
    input wire logic [11:0] o_cr_npd,
    input wire logic [7:0] o_cr_cplh,
    input wire logic [11:0] o_cr_cpld,
    input wire logic o_tx_valid,
    input wire logic [2:0] o_tx_msg,
    input wire logic o_rx_turn_off,
    input wire logic o_rx_drop,
    input wire logic o_rx_ur
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    AST_POSTED: assert property (o_cr_ph == 8'h08 && o_cr_pd == 12'h080)
        else $error("posted credits wrong");
    AST_NONPOSTED: assert property (o_cr_nph == 8'h04 && o_cr_npd == 12'h004)
        else $error("non-posted credits wrong");
    AST_CPL: assert property (o_cr_cplh == 8'h00 && o_cr_cpld == 12'h000)
        else $error("completion credits wrong");
    AST_WAKE_LOW: assert property (o_wake_n_o == 1'b0)
        else $error("wake data driven high");
    AST_NO_DEEMPH: assert property (o_beacon_deemph == 1'b0)
        else $error("beacon de-emphasis on");
    AST_TX: assert property (i_ce && i_tx_req && i_tx_msg != 3'h7 |=>
        o_tx_valid && o_tx_msg == $past(i_tx_msg)) else $error("tx not sent");
    AST_TX_BAD: assert property (i_ce && i_tx_req && i_tx_msg == 3'h7 |=>
        !o_tx_valid) else $error("bad tx code sent");
    AST_TURN_OFF: assert property (i_ce && i_rx_valid && i_rx_msg == 4'h1 |=>
        o_rx_turn_off) else $error("turn-off not processed");
    AST_UR: assert property (i_ce && i_rx_valid && i_rx_msg == 4'h6 |=>
        o_rx_ur && !o_rx_drop) else $error("vendor type 0 not UR");
    AST_DROP: assert property (i_ce && i_rx_valid && i_rx_msg inside {4'h3,
        4'h4, 4'h5, 4'h7} |=> o_rx_drop) else $error("message not dropped");
endmodule : puwcm_checker

bind puwcm_top puwcm_checker u_puwcm_checker (.*);

// *** bench/puwcm_upstream_model.sv ***
`timescale 1ns/10ps
// ==========================================================
// Upstream port: owns fundamental reset, link state, link clock.
module puwcm_upstream_model (
    input wire logic i_mclk,
    input wire logic i_wake_n,
    output logic o_link_clk,
    output logic o_perst_n,
    output logic o_link_in_l2
);
    initial begin
        o_link_clk = 1'b0;
        o_perst_n = 1'b1;
        o_link_in_l2 = 1'b0;
        forever #16 o_link_clk = ~o_link_clk;
    end
    task automatic set_l2(input logic v);
        @(negedge i_mclk);
        o_link_in_l2 = v;
    endtask : set_l2
    // Main power goes away first, so reset is asserted before L2 ends.
    task automatic drop_power();
        @(negedge i_mclk);
        o_perst_n = 1'b0;
    endtask : drop_power
    // A rising reset edge is only given once power is good again.
    task automatic power_good();
        repeat (4) @(negedge i_mclk);
        o_link_in_l2 = 1'b0;
        o_perst_n = 1'b1;
    endtask : power_good
endmodule : puwcm_upstream_model

// *** bench/puwcm_top_bench.sv ***
`timescale 1ns/10ps
module puwcm_top_bench;
    import puwcm_pkg::*;
    logic i_mclk = 0, i_rstn = 0, strap = 0, pme_n = 1, vc1 = 0;
    logic tx_req = 0, rx_valid = 0, lclk, perst_n, l2, wake_wire, ce = 1;
    logic [2:0] tx_msg = 0;
    logic [3:0] rx_msg = 0;
    logic [31:0] gen_ctrl = 0;
    logic ref125, bcn, bact, wo, woe, txv, a, t, s, d, u;
    logic [7:0] ph, nph, cplh;
    logic [11:0] pd, npd, cpld;
    logic [2:0] txm;
    int error_cnt = 0, check_count = 0, cyc = 0;
    initial forever #25 i_mclk = ~i_mclk;
    assign wake_wire = woe ? wo : 1'b1;
    puwcm_top u_puwcm_top (.i_mclk(i_mclk),
        .i_rstn(i_rstn), .i_ce(ce), .i_link_clk(lclk),
        .i_ref_clock_type_strap(strap), .i_perst_n(perst_n),
        .i_gen_ctrl(gen_ctrl), .i_link_in_l2(l2), .i_sec_pme_n(pme_n),
        .i_vc1_enable(vc1), .i_tx_req(tx_req), .i_tx_msg(tx_msg),
        .i_rx_valid(rx_valid), .i_rx_msg(rx_msg), .o_ref_sel_125(ref125),
        .o_beacon(bcn), .o_beacon_active(bact), .o_beacon_deemph(),
        .o_wake_n_o(wo), .o_wake_n_oe(woe), .o_cr_ph(ph), .o_cr_pd(pd),
        .o_cr_nph(nph), .o_cr_npd(npd), .o_cr_cplh(cplh), .o_cr_cpld(cpld),
        .o_tx_valid(txv), .o_tx_msg(txm), .o_rx_aspm_nak(a),
        .o_rx_turn_off(t), .o_rx_slot_pwr(s), .o_rx_drop(d), .o_rx_ur(u));
    puwcm_upstream_model u_puwcm_upstream_model (.i_mclk(i_mclk),
        .i_wake_n(wake_wire), .o_link_clk(lclk), .o_perst_n(perst_n),
        .o_link_in_l2(l2));
    // ======================================================
    // Shared checks.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_oe(input logic v);
        for (int k = 0; k < 30 && woe !== v; k++) @(negedge i_mclk);
    endtask : wait_oe
    task automatic final_report();
        $display("checks=%0d errors=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    // ======================================================
    // Scenarios.
    task automatic t_credits();
        for (int v = 0; v < 2; v++) begin
            @(negedge i_mclk) vc1 = v[0];
            @(negedge i_mclk);
            chk({ph, pd}, {8'h08, 12'h080});
            chk({nph, npd}, {8'h04, 12'h004});
            chk({cplh, cpld}, 0);
        end
    endtask : t_credits
    task automatic t_msgs();
        logic [4:0] e;
        for (int m = 0; m < 8; m++) begin
            e = m == 0 ? 5'h10 : m == 1 ? 5'h08 : m == 2 ? 5'h04 : 5'h02;
            if (m == 6) e = 5'h01;
            @(negedge i_mclk) {tx_req, tx_msg, rx_valid, rx_msg} = {1'b1,
                m[2:0], 1'b1, m[3:0]};
            @(negedge i_mclk) {tx_req, rx_valid} = 2'b00;
            chk(txv, m != 7);
            if (m < 7) chk(txm, m);
            chk({a, t, s, d, u}, e);
        end
    endtask : t_msgs
    task automatic t_wake(input logic ben);
        int n = 0;
        logic b;
        realtime t0, dt;
        @(negedge i_mclk) gen_ctrl = {21'h0, ben, 10'h0};
        u_puwcm_upstream_model.set_l2(1'b1);
        @(negedge i_mclk) pme_n = 0;
        wait_oe(1'b1);
        chk(wake_wire, 0);
        chk(bact, ben);
        b = bcn;
        t0 = 0.0;
        dt = 0.0;
        repeat (200) begin
            @(posedge lclk) #1;
            if (bcn !== b) begin
                n++;
                if (n == 1) t0 = $realtime;
                if (n == 2) dt = $realtime - t0;
            end
            b = bcn;
        end
        // Half period of a 500 kHz tone within 50 percent, in ns.
        chk(n >= 2 && dt >= 666.0 && dt <= 2000.0, ben);
        chk(n != 0, ben);
        @(negedge i_mclk) pme_n = 1;
        u_puwcm_upstream_model.drop_power();
        repeat (10) @(negedge i_mclk);
        chk({woe, bact}, {1'b1, ben});
        u_puwcm_upstream_model.power_good();
        wait_oe(1'b0);
        chk({wake_wire, woe, bact}, 3'b100);
        repeat (8) @(posedge lclk);
        chk(bcn, 1'b0);
    endtask : t_wake
    task automatic t_freeze();
        @(negedge i_mclk) {ce, rx_valid, rx_msg} = {1'b0, 1'b1, 4'h1};
        @(negedge i_mclk) rx_valid = 0;
        chk(t, 1'b0);
        ce = 1;
    endtask : t_freeze
    task automatic t_no_l2();
        @(negedge i_mclk) {gen_ctrl, pme_n} = {32'h0000_0400, 1'b0};
        repeat (15) @(negedge i_mclk);
        chk({woe, bact}, 0);
        pme_n = 1;
    endtask : t_no_l2
    task automatic t_strap();
        for (int v = 0; v < 2; v++) begin
            @(negedge i_mclk) strap = v[0];
            u_puwcm_upstream_model.drop_power();
            u_puwcm_upstream_model.power_good();
            repeat (8) @(negedge i_mclk);
            chk(ref125, v);
        end
    endtask : t_strap
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            final_report();
        end
    end
    initial begin
        repeat (12) @(negedge i_mclk);
        i_rstn = 1;
        t_credits();
        t_msgs();
        t_strap();
        t_wake(1'b1);
        t_wake(1'b0);
        t_no_l2();
        t_freeze();
        final_report();
    end
endmodule : puwcm_top_bench
